// ===== verilog/tcm_regs.svh
// Register offsets, field positions, reset values and mode codes of the timer channel block.
`ifndef TCM_REGS_SVH
`define TCM_REGS_SVH

`define TCM_OFF_EVENT_GEN     8'h14
`define TCM_OFF_MODE_LOW      8'h18
`define TCM_OFF_CHAN_ENABLE   8'h20
`define TCM_OFF_CMP1          8'h34
`define TCM_OFF_CMP2          8'h38
`define TCM_OFF_STATUS        8'h44

`define TCM_RST_MODE_LOW      16'h0000
`define TCM_RST_CHAN_ENABLE   6'h00
`define TCM_RST_CMP           16'h0000

`define TCM_EG_UPDATE_BIT     0
`define TCM_EG_CHAN2_BIT      2

`define TCM_ML_C1_SEL_LSB     0
`define TCM_ML_C1_SEL_MSB     1
`define TCM_ML_C1_PRELOAD_BIT 3
`define TCM_ML_C1_MODE_LSB    4
`define TCM_ML_C1_MODE_MSB    6
`define TCM_ML_C1_CLEAR_BIT   7
`define TCM_ML_C2_SEL_LSB     8
`define TCM_ML_C2_SEL_MSB     9
`define TCM_ML_C2_PRELOAD_BIT 11
`define TCM_ML_C2_MODE_LSB    12
`define TCM_ML_C2_MODE_MSB    14
`define TCM_ML_C2_CLEAR_BIT   15

`define TCM_CE_C1_ENABLE_BIT  0
`define TCM_CE_C1_POL_BIT     1
`define TCM_CE_C1N_POL_BIT    3
`define TCM_CE_C2_ENABLE_BIT  4
`define TCM_CE_C2_POL_BIT     5

`define TCM_SEL_OUTPUT        2'h0
`define TCM_SEL_TI2_A         2'h1
`define TCM_SEL_TI2_B         2'h2
`define TCM_SEL_TRC           2'h3

`define TCM_OC_FROZEN         3'h0
`define TCM_OC_SET_MATCH      3'h1
`define TCM_OC_CLR_MATCH      3'h2
`define TCM_OC_TOGGLE         3'h3
`define TCM_OC_FORCE_LOW      3'h4
`define TCM_OC_FORCE_HIGH     3'h5
`define TCM_OC_PWM1           3'h6
`define TCM_OC_PWM2           3'h7

`endif

// ===== verilog/tcm_pkg.sv
// Types shared by the timer channel mode and update generator block.
package tcm_pkg;

	// Avalon-MM request from the bus master.
	typedef struct packed {
		logic [7:0]  address;
		logic        read;
		logic        write;
		logic [31:0] writedata;
		logic [3:0]  byteenable;
	} tcm_avs_req_t;

	// Where channel 2 takes its capture signal from.
	typedef enum logic [1:0] {
		TCM_SRC_NONE,
		TCM_SRC_INPUT_TWO,
		TCM_SRC_TRIGGER
	} tcm_cap_src_t;

	// Counter requests raised by a software update event.
	typedef struct packed {
		logic counter_clear;
		logic counter_reload;
		logic prescaler_clear;
	} tcm_upd_req_t;

endpackage : tcm_pkg

// ===== verilog/tcm_oc_ref.sv
// Output reference generator for one compare channel.
`include "tcm_regs.svh"

module tcm_oc_ref #(
	parameter int CW = 16
) (
	// Clock and reset.
	input  wire logic          i_clk,
	input  wire logic          i_arst_n,
	// Channel configuration.
	input  wire logic          i_is_output,
	input  wire logic [2:0]    i_mode,
	input  wire logic          i_clear_enable,
	// Counter side.
	input  wire logic [CW-1:0] i_counter,
	input  wire logic [CW-1:0] i_compare,
	input  wire logic          i_count_down,
	input  wire logic          i_filtered_external_trigger,
	// Reference out, active high.
	output logic               o_ref
);

	logic match;
	logic below;
	logic above;
	logic ref_next;

	assign match = (i_counter == i_compare);
	assign below = (i_counter < i_compare);
	assign above = (i_counter > i_compare);

	always_comb begin
		ref_next = o_ref;
		case (i_mode)
			`TCM_OC_FROZEN: ref_next = o_ref;
			`TCM_OC_SET_MATCH: if (match) ref_next = 1'b1;
			`TCM_OC_CLR_MATCH: if (match) ref_next = 1'b0;
			`TCM_OC_TOGGLE: if (match) ref_next = ~o_ref;
			`TCM_OC_FORCE_LOW: ref_next = 1'b0;
			`TCM_OC_FORCE_HIGH: ref_next = 1'b1;
			`TCM_OC_PWM1: ref_next = i_count_down ? ~above : below;
			`TCM_OC_PWM2: ref_next = i_count_down ? above : ~below;
			default: ref_next = o_ref;
		endcase
		// The trigger clear overrides whatever the mode asks for.
		if (i_clear_enable && i_filtered_external_trigger) begin
			ref_next = 1'b0;
		end
		if (!i_is_output) begin
			ref_next = o_ref;
		end
	end

	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_ref <= 1'b0;
		end else begin
			o_ref <= ref_next;
		end
	end

endmodule : tcm_oc_ref

// ===== verilog/tcm_top.sv
// Timer channel mode control, software event generation and channel outputs.
//
// What this block does
// - A software update request clears the main counter when counting up or center-aligned.
// - A software update request reloads the main counter with the auto-reload value when counting down and not center-aligned.
// - A software update request clears the prescaler in the same cycle as the counter action.
// - The update request bit is write-only, reads zero, self-clears, and writing zero does nothing.
// - Writing one to the channel 2 event bit creates a channel 2 event, writing zero does nothing.
// - The channel 2 direction field takes writes only while channel 2 is disabled.
// - Direction 00 makes channel 2 an output, 01 and 10 make it an input from timer input two.
// - Direction 11 makes channel 2 an input from the internal trigger, valid with an internal source.
// - With the clear enable set, the channel 1 reference is forced low while the external trigger is high.
// - The channel 1 reference is active high and drives both channel 1 outputs through their polarity bits.
// - Frozen mode keeps the channel 1 reference unchanged whatever the compare result.
// - Mode 001 drives the channel 1 reference high on a compare match.
// - Channel 2 has the same control fields as channel 1 at bits 15, 14:12, 11 and 9:8.
// - Mode 010 clears on match, 011 toggles on match, 100 forces low and 101 forces high.
// - Mode 110 is high while below the compare value counting up and while not above it counting down, 111 is the inverse.
//
// The Avalon-MM register port is this design's own decision.
`include "tcm_regs.svh"

module tcm_top #(
	parameter int CW = 16
) (
	// Clock and reset.
	input  wire logic                 i_clk,
	input  wire logic                 i_arst_n,
	// Avalon-MM slave.
	input  wire tcm_pkg::tcm_avs_req_t i_avs,
	output logic [31:0]               o_avs_readdata,
	output logic                      o_avs_waitrequest,
	// Counter core.
	input  wire logic [CW-1:0]        i_main_counter_value,
	input  wire logic                 i_count_down,
	input  wire logic                 i_center_aligned,
	input  wire logic                 i_counter_update_event,
	output tcm_pkg::tcm_upd_req_t     o_update_req,
	// Trigger and input signals.
	input  wire logic                 i_filtered_external_trigger,
	input  wire logic                 i_timer_input_two,
	input  wire logic                 i_internal_trigger_capture_source,
	// Channel 2 input side.
	output logic                      o_chan2_event,
	output logic                      o_chan2_capture_in,
	output tcm_pkg::tcm_cap_src_t     o_chan2_capture_src,
	// Channel outputs.
	output logic                      o_chan1_main_output,
	output logic                      o_chan1_complement_output,
	output logic                      o_chan2_main_output
);

	////////////////////////////////////////////////////////////////////////////////
	// Registers and bus decode.

	logic [15:0]   mode_low_reg;
	logic [5:0]    chan_enable_reg;
	logic [CW-1:0] cmp_reg      [2];
	logic [CW-1:0] cmp_act_reg  [2];
	logic          wait_reg;
	logic [31:0]   rdata_next;
	logic          bus_req;
	logic          wr_take;
	logic [31:0]   wmask;
	logic [1:0]    chan_ref;
	logic          update_now;
	logic          ti2_meta_reg;
	logic          ti2_sync_reg;

	logic [1:0] chan1_direction_select;
	logic [1:0] chan2_direction_select;
	logic [2:0] chan1_compare_mode;
	logic [2:0] chan2_compare_mode;
	logic       chan1_ref_clear_enable;
	logic       chan2_ref_clear_enable;
	logic       chan1_enable_bit;
	logic       chan2_enable_bit;

	assign chan1_direction_select = mode_low_reg[`TCM_ML_C1_SEL_MSB:`TCM_ML_C1_SEL_LSB];
	assign chan2_direction_select = mode_low_reg[`TCM_ML_C2_SEL_MSB:`TCM_ML_C2_SEL_LSB];
	assign chan1_compare_mode     = mode_low_reg[`TCM_ML_C1_MODE_MSB:`TCM_ML_C1_MODE_LSB];
	assign chan2_compare_mode     = mode_low_reg[`TCM_ML_C2_MODE_MSB:`TCM_ML_C2_MODE_LSB];
	assign chan1_ref_clear_enable = mode_low_reg[`TCM_ML_C1_CLEAR_BIT];
	assign chan2_ref_clear_enable = mode_low_reg[`TCM_ML_C2_CLEAR_BIT];
	assign chan1_enable_bit       = chan_enable_reg[`TCM_CE_C1_ENABLE_BIT];
	assign chan2_enable_bit       = chan_enable_reg[`TCM_CE_C2_ENABLE_BIT];

	assign bus_req = i_avs.read | i_avs.write;
	// A write lands on the edge where the master sees waitrequest low.
	assign wr_take = i_avs.write & ~wait_reg;
	assign wmask   = {{8{i_avs.byteenable[3]}}, {8{i_avs.byteenable[2]}},
			{8{i_avs.byteenable[1]}}, {8{i_avs.byteenable[0]}}};

	// One wait cycle, then one cycle with waitrequest low.
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			wait_reg <= 1'b1;
		end else if (bus_req && wait_reg) begin
			wait_reg <= 1'b0;
		end else begin
			wait_reg <= 1'b1;
		end
	end

	always_comb begin
		rdata_next = 32'h0000_0000;
		case (i_avs.address)
			`TCM_OFF_EVENT_GEN: rdata_next = 32'h0000_0000;
			`TCM_OFF_MODE_LOW: rdata_next[15:0] = mode_low_reg;
			`TCM_OFF_CHAN_ENABLE: rdata_next[5:0] = chan_enable_reg;
			`TCM_OFF_CMP1: rdata_next[CW-1:0] = cmp_reg[0];
			`TCM_OFF_CMP2: rdata_next[CW-1:0] = cmp_reg[1];
			`TCM_OFF_STATUS: rdata_next[3:0] = {o_chan2_capture_src, chan_ref};
			default: rdata_next = 32'h0000_0000;
		endcase
	end

	// Read data is captured while waitrequest is still high and holds over the answer cycle.
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_avs_readdata <= 32'h0000_0000;
		end else if (i_avs.read && wait_reg) begin
			o_avs_readdata <= rdata_next;
		end
	end

	assign o_avs_waitrequest = wait_reg;

	////////////////////////////////////////////////////////////////////////////////
	// Mode control register.

	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			mode_low_reg <= `TCM_RST_MODE_LOW;
		end else if (wr_take && i_avs.address == `TCM_OFF_MODE_LOW) begin
			mode_low_reg[15:10] <= (mode_low_reg[15:10] & ~wmask[15:10])
					| (i_avs.writedata[15:10] & wmask[15:10]);
			mode_low_reg[7:2] <= (mode_low_reg[7:2] & ~wmask[7:2])
					| (i_avs.writedata[7:2] & wmask[7:2]);
			// A live channel keeps its direction.
			if (!chan2_enable_bit && i_avs.byteenable[1]) begin
				mode_low_reg[`TCM_ML_C2_SEL_MSB:`TCM_ML_C2_SEL_LSB] <=
						i_avs.writedata[`TCM_ML_C2_SEL_MSB:`TCM_ML_C2_SEL_LSB];
			end
			if (!chan1_enable_bit && i_avs.byteenable[0]) begin
				mode_low_reg[`TCM_ML_C1_SEL_MSB:`TCM_ML_C1_SEL_LSB] <=
						i_avs.writedata[`TCM_ML_C1_SEL_MSB:`TCM_ML_C1_SEL_LSB];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Channel enable and polarity register.

	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			chan_enable_reg <= `TCM_RST_CHAN_ENABLE;
		end else if (wr_take && i_avs.address == `TCM_OFF_CHAN_ENABLE && i_avs.byteenable[0]) begin
			chan_enable_reg <= i_avs.writedata[5:0];
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Software event generation.

	assign update_now = wr_take && i_avs.address == `TCM_OFF_EVENT_GEN
			&& i_avs.byteenable[0] && i_avs.writedata[`TCM_EG_UPDATE_BIT];

	// Each request is a one-cycle pulse; nothing is stored, so the bit reads back zero.
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_update_req <= '0;
		end else begin
			o_update_req.counter_clear   <= update_now
					&& (!i_count_down || i_center_aligned);
			o_update_req.counter_reload  <= update_now
					&& i_count_down && !i_center_aligned;
			o_update_req.prescaler_clear <= update_now;
		end
	end

	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_chan2_event <= 1'b0;
		end else begin
			o_chan2_event <= wr_take && i_avs.address == `TCM_OFF_EVENT_GEN
					&& i_avs.byteenable[0] && i_avs.writedata[`TCM_EG_CHAN2_BIT];
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Compare values with optional preload, and the two reference generators.

	genvar ch;
	generate
		for (ch = 0; ch < 2; ch++) begin : g_chan
			localparam logic [7:0] OFF = (ch == 0) ? `TCM_OFF_CMP1 : `TCM_OFF_CMP2;
			localparam int PL_BIT = (ch == 0) ? `TCM_ML_C1_PRELOAD_BIT : `TCM_ML_C2_PRELOAD_BIT;
			logic is_output;
			logic [2:0] mode;
			logic clr_en;

			assign is_output = (ch == 0) ? (chan1_direction_select == `TCM_SEL_OUTPUT)
					: (chan2_direction_select == `TCM_SEL_OUTPUT);
			assign mode   = (ch == 0) ? chan1_compare_mode : chan2_compare_mode;
			assign clr_en = (ch == 0) ? chan1_ref_clear_enable : chan2_ref_clear_enable;

			always_ff @(posedge i_clk or negedge i_arst_n) begin
				if (!i_arst_n) begin
					cmp_reg[ch] <= `TCM_RST_CMP;
				end else if (wr_take && i_avs.address == OFF) begin
					cmp_reg[ch] <= (cmp_reg[ch] & ~wmask[CW-1:0])
							| (i_avs.writedata[CW-1:0] & wmask[CW-1:0]);
				end
			end

			// The active value follows at once, or waits for an update event under preload.
			always_ff @(posedge i_clk or negedge i_arst_n) begin
				if (!i_arst_n) begin
					cmp_act_reg[ch] <= `TCM_RST_CMP;
				end else if (!mode_low_reg[PL_BIT] || i_counter_update_event
						|| o_update_req.prescaler_clear) begin
					cmp_act_reg[ch] <= cmp_reg[ch];
				end
			end

			tcm_oc_ref #(
				.CW (CW)
			) u_ref (
				.i_clk                       (i_clk),
				.i_arst_n                    (i_arst_n),
				.i_is_output                 (is_output),
				.i_mode                      (mode),
				.i_clear_enable              (clr_en),
				.i_counter                   (i_main_counter_value),
				.i_compare                   (cmp_act_reg[ch]),
				.i_count_down                (i_count_down),
				.i_filtered_external_trigger (i_filtered_external_trigger),
				.o_ref                       (chan_ref[ch])
			);
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////////
	// Channel outputs through their polarity bits.

	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_chan1_main_output       <= 1'b0;
			o_chan1_complement_output <= 1'b0;
			o_chan2_main_output       <= 1'b0;
		end else begin
			o_chan1_main_output       <= chan_ref[0]
					^ chan_enable_reg[`TCM_CE_C1_POL_BIT];
			o_chan1_complement_output <= ~chan_ref[0]
					^ chan_enable_reg[`TCM_CE_C1N_POL_BIT];
			o_chan2_main_output       <= chan_ref[1]
					^ chan_enable_reg[`TCM_CE_C2_POL_BIT];
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Channel 2 capture source selection.

	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			ti2_meta_reg <= 1'b0;
			ti2_sync_reg <= 1'b0;
		end else begin
			ti2_meta_reg <= i_timer_input_two;
			ti2_sync_reg <= ti2_meta_reg;
		end
	end

	// The trigger source is only meaningful when an internal trigger is selected upstream.
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_chan2_capture_src <= tcm_pkg::TCM_SRC_NONE;
			o_chan2_capture_in  <= 1'b0;
		end else begin
			case (chan2_direction_select)
				`TCM_SEL_TI2_A, `TCM_SEL_TI2_B: begin
					o_chan2_capture_src <= tcm_pkg::TCM_SRC_INPUT_TWO;
					o_chan2_capture_in  <= ti2_sync_reg;
				end
				`TCM_SEL_TRC: begin
					o_chan2_capture_src <= tcm_pkg::TCM_SRC_TRIGGER;
					o_chan2_capture_in  <= i_internal_trigger_capture_source;
				end
				default: begin
					o_chan2_capture_src <= tcm_pkg::TCM_SRC_NONE;
					o_chan2_capture_in  <= 1'b0;
				end
			endcase
		end
	end

endmodule : tcm_top

// ===== dv/tcm_top_chk.sv
// Concurrent checks on the ports of the timer channel block.
`include "tcm_regs.svh"

module tcm_top_chk (
	// Clock and reset.
	input  wire logic                  i_clk,
	input  wire logic                  i_arst_n,
	// Register bus.
	input  wire tcm_pkg::tcm_avs_req_t i_avs,
	input  wire logic [31:0]           o_avs_readdata,
	input  wire logic                  o_avs_waitrequest,
	// Counter and trigger side.
	input  wire logic                  i_count_down,
	input  wire logic                  i_center_aligned,
	input  wire logic                  i_filtered_external_trigger,
	input  wire tcm_pkg::tcm_upd_req_t o_update_req,
	// Channel outputs.
	input  wire logic                  o_chan2_event,
	input  wire logic                  o_chan1_main_output,
	input  wire logic                  o_chan1_complement_output
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_arst_n);

	logic       wr_done;
	logic       evt_wr;
	logic       upd_wr;
	logic [7:0] mode_sh;
	logic [3:0] en_sh;
	logic [2:0] clr_cnt;

	assign wr_done = i_avs.write && !o_avs_waitrequest;
	assign evt_wr  = wr_done && i_avs.address == `TCM_OFF_EVENT_GEN && i_avs.byteenable[0];
	assign upd_wr  = evt_wr && i_avs.writedata[`TCM_EG_UPDATE_BIT];

	////////////////////////////////////////////////////////////////////////////////
	// Shadows of the channel 1 settings and a count of cycles under a steady clear.
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			mode_sh <= 8'h00;
			en_sh   <= 4'h0;
		end else if (wr_done && i_avs.address == `TCM_OFF_MODE_LOW) begin
			mode_sh <= i_avs.writedata[7:0];
		end else if (wr_done && i_avs.address == `TCM_OFF_CHAN_ENABLE) begin
			en_sh <= i_avs.writedata[3:0];
		end
	end

	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			clr_cnt <= 3'h0;
		end else if (wr_done || !i_filtered_external_trigger || !mode_sh[7] ||
				mode_sh[1:0] != 2'h0 || !en_sh[0]) begin
			clr_cnt <= 3'h0;
		end else if (clr_cnt != 3'h4) begin
			clr_cnt <= clr_cnt + 3'h1;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	upd_clear_a: assert property (
		evt_wr && i_avs.writedata[0] && (!i_count_down || i_center_aligned)
		|=> o_update_req == 3'h5) else $error("update clear pulse wrong");
	upd_reload_a: assert property (
		evt_wr && i_avs.writedata[0] && i_count_down && !i_center_aligned
		|=> o_update_req == 3'h3) else $error("update reload pulse wrong");
	upd_cause_a: assert property (
		o_update_req.prescaler_clear |-> $past(upd_wr))
		else $error("update pulse without a request");
	upd_once_a: assert property (
		o_update_req.prescaler_clear |=> !o_update_req.prescaler_clear)
		else $error("update pulse longer than one cycle");
	chan2_evt_a: assert property (
		evt_wr |=> o_chan2_event == $past(i_avs.writedata[2]))
		else $error("channel 2 event does not follow the written bit");
	evt_read_a: assert property (
		i_avs.read && !o_avs_waitrequest && i_avs.address == `TCM_OFF_EVENT_GEN
		|-> o_avs_readdata == 32'h0) else $error("event register reads nonzero");
	bus_answer_a: assert property (
		(i_avs.read || i_avs.write) && o_avs_waitrequest |=> !o_avs_waitrequest)
		else $error("bus answer late");
	bus_pulse_a: assert property (
		!o_avs_waitrequest |=> o_avs_waitrequest) else $error("waitrequest low too long");
	trig_clear_a: assert property (
		clr_cnt == 3'h4 |-> o_chan1_main_output == en_sh[1] &&
		o_chan1_complement_output == !en_sh[3]) else $error("trigger clear not seen at pins");
endmodule : tcm_top_chk

// ===== dv/tcm_top_bench.sv
// Self-checking testbench of the timer channel block.
`include "tcm_regs.svh"

module tcm_top_bench;
	timeunit 1ns;
	timeprecision 1ps;

	logic                  i_clk;
	logic                  i_arst_n;
	tcm_pkg::tcm_avs_req_t avs;
	logic [31:0]           rdata;
	logic                  waitreq;
	logic [15:0]           cnt;
	logic                  down;
	logic                  center;
	logic                  upd_evt;
	tcm_pkg::tcm_upd_req_t upd;
	logic                  etr;
	logic                  ti2;
	logic                  itrig;
	logic                  c2_evt;
	logic                  c2_cap;
	tcm_pkg::tcm_cap_src_t c2_src;
	logic                  c1_main;
	logic                  c1_comp;
	logic                  c2_main;
	int                    n_fail;
	int                    samples_checked;

	tcm_top #(.CW(16)) i_tcm_top (
		.i_clk(i_clk), .i_arst_n(i_arst_n), .i_avs(avs), .o_avs_readdata(rdata),
		.o_avs_waitrequest(waitreq), .i_main_counter_value(cnt), .i_count_down(down),
		.i_center_aligned(center), .i_counter_update_event(upd_evt), .o_update_req(upd),
		.i_filtered_external_trigger(etr), .i_timer_input_two(ti2),
		.i_internal_trigger_capture_source(itrig), .o_chan2_event(c2_evt),
		.o_chan2_capture_in(c2_cap), .o_chan2_capture_src(c2_src),
		.o_chan1_main_output(c1_main), .o_chan1_complement_output(c1_comp),
		.o_chan2_main_output(c2_main)
	);

	initial begin
		i_clk = 1'b0;
		forever #5 i_clk = ~i_clk;
	end

	////////////////////////////////////////////////////////////////////////////////
	task automatic finish_test();
		$display("checks %0d mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : finish_test

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		samples_checked++;
		if (got !== exp) begin
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
			n_fail++;
		end
	endtask : chk

	task automatic tick(input int n);
		repeat (n) @(posedge i_clk);
	endtask : tick

	// One Avalon access, held until waitrequest is sampled low.
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
			output logic [31:0] q);
		int n;
		n = 0;
		// Let an edge pass so that the previous release is seen before the next request.
		@(posedge i_clk);
		avs.address    <= a;
		avs.writedata  <= d;
		avs.byteenable <= 4'hf;
		avs.read       <= !wr;
		avs.write      <= wr;
		@(posedge i_clk);
		while (waitreq !== 1'b0 && n < 50) begin
			@(posedge i_clk);
			n++;
		end
		q = rdata;
		avs.read  <= 1'b0;
		avs.write <= 1'b0;
		chk("bus answer", 32'h0, {31'h0, n == 50});
	endtask : bus

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask : wr

	task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] q;
		bus(1'b0, a, 32'h0, q);
		chk(what, exp, q);
	endtask : rd_chk

	////////////////////////////////////////////////////////////////////////////////
	task automatic t_regs();
		rd_chk("mode reset", `TCM_OFF_MODE_LOW, 32'h0);
		wr(`TCM_OFF_MODE_LOW, 32'hffff_ffff);
		rd_chk("mode ones", `TCM_OFF_MODE_LOW, 32'h0000_ffff);
		wr(`TCM_OFF_MODE_LOW, 32'h0);
		wr(`TCM_OFF_EVENT_GEN, 32'h0);
		rd_chk("event read", `TCM_OFF_EVENT_GEN, 32'h0);
		wr(8'h7c, 32'hffff_ffff);
		rd_chk("unmapped", 8'h7c, 32'h0);
		$display("test regs done");
	endtask : t_regs

	task automatic t_update();
		logic [1:0] dc;
		for (int i = 0; i < 4; i++) begin
			dc = 2'(i);
			down   <= dc[1];
			center <= dc[0];
			wr(`TCM_OFF_EVENT_GEN, 32'h1);
			@(posedge i_clk);
			chk("update", {29'h0, !dc[1] || dc[0], dc[1] && !dc[0], 1'b1}, 32'(upd));
		end
		wr(`TCM_OFF_EVENT_GEN, 32'h4);
		@(posedge i_clk);
		chk("chan2 event", 32'h1, {31'h0, c2_evt});
		chk("no update", 32'h0, 32'(upd));
		wr(`TCM_OFF_EVENT_GEN, 32'h0);
		@(posedge i_clk);
		chk("zero write", 32'h0, {28'h0, upd, c2_evt});
		$display("test update done");
	endtask : t_update

	task automatic t_select();
		ti2   <= 1'b1;
		itrig <= 1'b0;
		wr(`TCM_OFF_CHAN_ENABLE, 32'h10);
		wr(`TCM_OFF_MODE_LOW, 32'h3300);
		rd_chk("locked select", `TCM_OFF_MODE_LOW, 32'h3000);
		wr(`TCM_OFF_CHAN_ENABLE, 32'h0);
		for (int s = 3; s >= 0; s--) begin
			wr(`TCM_OFF_MODE_LOW, 32'(s) << 8);
			tick(4);
			chk("capture source", s == 3 ? 32'h2 : (s == 0 ? 32'h0 : 32'h1), 32'(c2_src));
			if (s != 0) chk("capture input", {31'h0, s != 3}, {31'h0, c2_cap});
		end
		itrig <= 1'b1;
		wr(`TCM_OFF_MODE_LOW, 32'h300);
		tick(4);
		chk("trigger input", 32'h1, {31'h0, c2_cap});
		wr(`TCM_OFF_MODE_LOW, 32'h0);
		$display("test select done");
	endtask : t_select

	// Each step is mode, direction, counter and expected reference, one hex digit each.
	task automatic t_compare();
		logic [15:0] steps [16] = '{16'h1030, 16'h1051, 16'h0031, 16'h4030, 16'h0050,
			16'h5031, 16'h2031, 16'h2050, 16'h0030, 16'h6031, 16'h6070, 16'h6170,
			16'h6131, 16'h7130, 16'h7030, 16'h7071};
		logic [31:0] q;
		wr(`TCM_OFF_CMP1, 32'h5);
		wr(`TCM_OFF_CHAN_ENABLE, 32'h1);
		foreach (steps[i]) begin
			down <= steps[i][8];
			cnt  <= 16'(steps[i][7:4]);
			wr(`TCM_OFF_MODE_LOW, {25'h0, steps[i][14:12], 4'h0});
			tick(3);
			bus(1'b0, `TCM_OFF_STATUS, 32'h0, q);
			chk("chan1 ref", 32'(steps[i][0]), q & 32'h1);
			chk("chan1 pins", {30'h0, steps[i][0], !steps[i][0]}, {30'h0, c1_main, c1_comp});
		end
		wr(`TCM_OFF_MODE_LOW, 32'h30);
		cnt <= 16'h5;
		@(posedge i_clk);
		cnt <= 16'h6;
		tick(3);
		bus(1'b0, `TCM_OFF_STATUS, 32'h0, q);
		chk("toggle", 32'h0, q & 32'h1);
		wr(`TCM_OFF_MODE_LOW, 32'hd0);
		wr(`TCM_OFF_CHAN_ENABLE, 32'hb);
		etr <= 1'b1;
		tick(5);
		chk("cleared pins", 32'h2, {30'h0, c1_main, c1_comp});
		etr <= 1'b0;
		tick(5);
		chk("released pins", 32'h1, {30'h0, c1_main, c1_comp});
		wr(`TCM_OFF_MODE_LOW, 32'h50);
		etr <= 1'b1;
		tick(5);
		chk("clear disabled", 32'h1, {30'h0, c1_main, c1_comp});
		wr(`TCM_OFF_MODE_LOW, 32'h5000);
		tick(3);
		chk("chan2 pin high", 32'h1, {31'h0, c2_main});
		wr(`TCM_OFF_MODE_LOW, 32'h4000);
		tick(3);
		chk("chan2 pin low", 32'h0, {31'h0, c2_main});
		$display("test compare done");
	endtask : t_compare

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		i_arst_n        = 1'b0;
		avs             = '0;
		cnt             = 16'h0;
		down            = 1'b0;
		center          = 1'b0;
		upd_evt         = 1'b0;
		etr             = 1'b0;
		ti2             = 1'b0;
		itrig           = 1'b0;
		n_fail          = 0;
		samples_checked = 0;
		repeat (20) @(posedge i_clk);
		i_arst_n <= 1'b1;
		@(posedge i_clk);
		t_regs();
		t_update();
		t_select();
		t_compare();
		finish_test();
	end

	initial begin
		repeat (20000) @(posedge i_clk);
		n_fail++;
		finish_test();
	end
endmodule : tcm_top_bench

bind tcm_top tcm_top_chk i_tcm_top_chk (
	.i_clk(i_clk), .i_arst_n(i_arst_n), .i_avs(i_avs), .o_avs_readdata(o_avs_readdata),
	.o_avs_waitrequest(o_avs_waitrequest), .i_count_down(i_count_down),
	.i_center_aligned(i_center_aligned), .o_update_req(o_update_req),
	.i_filtered_external_trigger(i_filtered_external_trigger), .o_chan2_event(o_chan2_event),
	.o_chan1_main_output(o_chan1_main_output),
	.o_chan1_complement_output(o_chan1_complement_output)
);
